// [src/wdr_map.svh]
`ifndef WDR_MAP_SVH
`define WDR_MAP_SVH

// Register byte addresses (APB, one aligned word each)
`define WDR_MISC_ADDR      12'h038
`define WDR_IRQ_STAT_ADDR  12'h040
`define WDR_IRQ_MASK_ADDR  12'h044

// Miscellaneous control field positions
`define WDR_TEST_HI_BIT    7
`define WDR_EN_BIT         3
`define WDR_PS_BIT         2
`define WDR_TEST_LO_MSB    1

// Interrupt status layout
`define WDR_IRQ_TICK_BIT   0
`define WDR_IRQ_CLEAR_BIT  1
`define WDR_IRQ_W          2

// Terminal counts in 2 Hz ticks
`define WDR_TC_SHORT       5'h04
`define WDR_TC_LONG        5'h10

// Reset request pulse length in pclk cycles
`define WDR_RST_PULSE      4'h8

`endif

// [src/wdr_pkg.sv]
package wdr_pkg;

    typedef enum logic [2:0] {
        WDR_IDLE  = 3'b001,
        WDR_COUNT = 3'b010,
        WDR_FIRE  = 3'b100
    } wdr_state_t;

endpackage

// [src/wdr_tick_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with rising-edge pulse on the 2 Hz tick input
module wdr_tick_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tick_in,
    output logic      tick_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic pulse;
    } wdr_sync_t;

    wdr_sync_t st_ff;
    wdr_sync_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Change counts once stages two and three agree
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.s1    = tick_in;
        nxt_st.s2    = st_ff.s1;
        nxt_st.s3    = st_ff.s2;
        // Accepted level resets to the idle low of the pin, so no false edge
        nxt_st.lvl   = (st_ff.s2 == st_ff.s3) ? st_ff.s3 : st_ff.lvl;
        nxt_st.pulse = (st_ff.s2 == st_ff.s3) & st_ff.s3 & ~st_ff.lvl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_pulse = st_ff.pulse;
endmodule // wdr_tick_sync

`default_nettype wire

// [src/wdr_irq.sv]
`timescale 1ns/1ps
`default_nettype none

`include "wdr_map.svh"

// Sticky status with write-one-to-clear and a mask
module wdr_irq (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [`WDR_IRQ_W-1:0]   events,
    input  wire logic [`WDR_IRQ_W-1:0]   clr_mask,
    input  wire logic                    mask_we,
    input  wire logic [`WDR_IRQ_W-1:0]   mask_wdata,
    output logic      [`WDR_IRQ_W-1:0]   status,
    output logic      [`WDR_IRQ_W-1:0]   mask,
    output logic                         irq
);
    typedef struct packed {
        logic [`WDR_IRQ_W-1:0] stat;
        logic [`WDR_IRQ_W-1:0] msk;
        logic                  irq;
    } wdr_irq_st_t;

    wdr_irq_st_t st_ff;
    wdr_irq_st_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Set wins over clear so an event in the clearing cycle is kept
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.stat = (st_ff.stat & ~clr_mask) | events;
        if (mask_we) begin
            nxt_st.msk = mask_wdata;
        end
        nxt_st.irq  = |(nxt_st.stat & nxt_st.msk);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign status = st_ff.stat;
    assign mask   = st_ff.msk;
    assign irq    = st_ff.irq;
endmodule // wdr_irq

`default_nettype wire

// [src/wdr_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none

`include "wdr_map.svh"

// Contract
// - The counter runs only while the enable flag in bit 3 is set; otherwise it idles.
// - Two timeout lengths are offered, picked by the period select bit 2.
// - The counter advances once per 2 Hz tick from the base timer.
// - A timeout is declared when the count reaches 4 (short) or 16 (long).
// - On timeout a reset request is driven to the whole system.
// - Every write to the control register while counting clears the tick counter whatever the data.
// - Any system reset clears the enable flag so the watchdog stays idle.
module wdr_watchdog (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        tick_2hz,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sys_reset_req,
    output logic             irq
);
    import wdr_pkg::*;

    typedef struct packed {
        wdr_state_t  state;
        logic        en;
        logic        ps;
        logic [2:0]  test;
        logic [4:0]  cnt;
        logic        wd_caused;
        logic [3:0]  pulse_cnt;
        logic        rst_req;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } wdr_st_t;

    wdr_st_t st_ff;
    wdr_st_t nxt_st;

    logic                  tick;
    logic [`WDR_IRQ_W-1:0] irq_stat;
    logic [`WDR_IRQ_W-1:0] irq_mask;
    logic                  irq_lvl;
    logic [`WDR_IRQ_W-1:0] irq_events;
    logic [`WDR_IRQ_W-1:0] irq_clr;
    logic                  mask_we;

    // Terminal count for the selected period
    function automatic logic [4:0] term_count(input logic ps);
        return ps ? `WDR_TC_LONG : `WDR_TC_SHORT;
    endfunction

    // Address decode shared by read and write paths
    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        return a == ref_a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    wdr_tick_sync u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .tick_in    (tick_2hz),
        .tick_pulse (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access phase of APB; answer in the cycle after penable rises
    logic acc;
    logic wr_misc;
    assign acc     = psel & penable & ~st_ff.ready;
    assign wr_misc = acc & pwrite & is_addr(paddr, `WDR_MISC_ADDR);
    assign mask_we = acc & pwrite & pstrb[0] & is_addr(paddr, `WDR_IRQ_MASK_ADDR);

    always_comb begin
        irq_clr = '0;
        if (acc && pwrite && pstrb[0] && is_addr(paddr, `WDR_IRQ_STAT_ADDR)) begin
            irq_clr = pwdata[`WDR_IRQ_W-1:0];
        end
    end

    // Events: each tick seen in WDR_COUNT and each software clear
    assign irq_events[`WDR_IRQ_TICK_BIT]  = tick & (st_ff.state == WDR_COUNT);
    assign irq_events[`WDR_IRQ_CLEAR_BIT] = wr_misc;

    wdr_irq u_irq (
        .pclk       (pclk),
        .presetn    (presetn),
        .events     (irq_events),
        .clr_mask   (irq_clr),
        .mask_we    (mask_we),
        .mask_wdata (pwdata[`WDR_IRQ_W-1:0]),
        .status     (irq_stat),
        .mask       (irq_mask),
        .irq        (irq_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sequencing and register file
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ready = acc;
        nxt_st.err   = 1'b0;
        nxt_st.rdata = 32'h0000_0000;

        // Register writes; byte lane 0 holds all the control bits
        if (wr_misc && pstrb[0]) begin
            nxt_st.en   = pwdata[`WDR_EN_BIT];
            nxt_st.ps   = pwdata[`WDR_PS_BIT];
            nxt_st.test = {pwdata[`WDR_TEST_HI_BIT], pwdata[`WDR_TEST_LO_MSB:0]};
        end

        // Reads; unmapped addresses return zero with an error
        if (acc && !pwrite) begin
            if (is_addr(paddr, `WDR_MISC_ADDR)) begin
                nxt_st.rdata[`WDR_TEST_HI_BIT]    = st_ff.test[2];
                nxt_st.rdata[`WDR_EN_BIT]         = st_ff.wd_caused;
                nxt_st.rdata[`WDR_PS_BIT]         = st_ff.ps;
                nxt_st.rdata[`WDR_TEST_LO_MSB:0]  = st_ff.test[1:0];
            end else if (is_addr(paddr, `WDR_IRQ_STAT_ADDR)) begin
                nxt_st.rdata[`WDR_IRQ_W-1:0] = irq_stat;
            end else if (is_addr(paddr, `WDR_IRQ_MASK_ADDR)) begin
                nxt_st.rdata[`WDR_IRQ_W-1:0] = irq_mask;
            end else begin
                nxt_st.err = 1'b1;
            end
        end else if (acc && pwrite && !is_addr(paddr, `WDR_MISC_ADDR)
                     && !is_addr(paddr, `WDR_IRQ_STAT_ADDR)
                     && !is_addr(paddr, `WDR_IRQ_MASK_ADDR)) begin
            nxt_st.err = 1'b1;
        end

        unique case (st_ff.state)
            WDR_IDLE: begin
                nxt_st.cnt     = 5'h00;
                nxt_st.rst_req = 1'b0;
                if (nxt_st.en) begin
                    nxt_st.state = WDR_COUNT;
                end
            end
            WDR_COUNT: begin
                if (!nxt_st.en) begin
                    nxt_st.state = WDR_IDLE;
                    nxt_st.cnt   = 5'h00;
                end else if (wr_misc) begin
                    nxt_st.cnt = 5'h00;
                end else if (tick) begin
                    nxt_st.cnt = st_ff.cnt + 5'h01;
                    if (st_ff.cnt + 5'h01 >= term_count(st_ff.ps)) begin
                        nxt_st.state     = WDR_FIRE;
                        nxt_st.rst_req   = 1'b1;
                        nxt_st.pulse_cnt = `WDR_RST_PULSE;
                        nxt_st.wd_caused = 1'b1;
                    end
                end
            end
            WDR_FIRE: begin
                // The requested system reset will also hit presetn; until then hold
                // the request and return to idle with the enable cleared
                nxt_st.pulse_cnt = st_ff.pulse_cnt - 4'h1;
                if (st_ff.pulse_cnt == 4'h1) begin
                    nxt_st.rst_req = 1'b0;
                    nxt_st.state   = WDR_IDLE;
                    nxt_st.en      = 1'b0;
                    nxt_st.cnt     = 5'h00;
                end
            end
            default: begin
                nxt_st.state   = WDR_IDLE;
                nxt_st.rst_req = 1'b0;
            end
        endcase
    end

    // Reset clears enable but keeps nothing else; the cause flag lives in the
    // always-on domain in a real chip, here it survives only the internal pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff       <= '0;
            st_ff.state <= WDR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign prdata        = st_ff.rdata;
    assign pready        = st_ff.ready;
    assign pslverr       = st_ff.err;
    assign sys_reset_req = st_ff.rst_req;
    assign irq           = irq_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence misc_write_s;
        psel && penable && !pready && pwrite && paddr == `WDR_MISC_ADDR;
    endsequence

    // A tick that the counter takes: counting, still enabled, no clearing write
    sequence counted_tick_s;
        st_ff.state == WDR_COUNT && nxt_st.en && !wr_misc && tick;
    endsequence

    // The reset request stands for the whole pulse and then drops
    sequence fire_pulse_s;
        sys_reset_req [*8] ##1 !sys_reset_req;
    endsequence

    idle_no_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        !st_ff.en && st_ff.state == WDR_IDLE |=> !sys_reset_req)
        else $error("reset request while disabled");

    clear_counter_a: assert property (@(posedge pclk) disable iff (!presetn)
        misc_write_s ##0 (st_ff.state == WDR_COUNT) |=> st_ff.cnt == 5'h00)
        else $error("write did not clear counter");

    tick_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && nxt_st.en && !wr_misc && tick
        |=> st_ff.cnt == $past(st_ff.cnt) + 5'h01)
        else $error("tick did not advance counter");

    short_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && !st_ff.ps && nxt_st.en && !wr_misc && tick
        && st_ff.cnt == 5'h03 |=> sys_reset_req)
        else $error("no timeout at count 4");

    long_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && st_ff.ps && st_ff.cnt < 5'h0f |=> !sys_reset_req)
        else $error("long period fired early");

    reset_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_reset_req) |-> fire_pulse_s)
        else $error("reset request pulse length wrong");

    cause_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_reset_req) |-> st_ff.wd_caused)
        else $error("cause flag not set on timeout");

    fire_disables_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sys_reset_req) |-> !st_ff.en && st_ff.state == WDR_IDLE)
        else $error("enable not cleared after timeout");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("APB answer late");

    long_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
        counted_tick_s ##0 (st_ff.ps && st_ff.cnt == 5'h0f) |=> sys_reset_req)
        else $error("no timeout at count 16");

    short_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && !st_ff.ps && st_ff.cnt < 5'h03 |=> !sys_reset_req)
        else $error("short period fired early");

    tick_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && nxt_st.en && !wr_misc && !tick |=> $stable(st_ff.cnt))
        else $error("counter moved without a tick");

    disable_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.state == WDR_COUNT && !nxt_st.en
        |=> st_ff.state == WDR_IDLE && st_ff.cnt == 5'h00)
        else $error("counter kept running when disabled");

    enable_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_misc && pstrb[0] && pwdata[`WDR_EN_BIT] && st_ff.state == WDR_IDLE
        |=> st_ff.en && st_ff.state == WDR_COUNT)
        else $error("enable write did not start counting");

    cause_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && paddr == `WDR_MISC_ADDR
        |=> prdata[`WDR_EN_BIT] == $past(st_ff.wd_caused))
        else $error("bit 3 read does not show the cause flag");

    fire_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_reset_req) |-> $past(tick) && $past(st_ff.state) == WDR_COUNT)
        else $error("reset request without a counted tick");

    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && paddr != `WDR_MISC_ADDR && paddr != `WDR_IRQ_STAT_ADDR
        && paddr != `WDR_IRQ_MASK_ADDR |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("APB answer longer than one cycle");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(irq_stat & irq_mask))
        else $error("interrupt level does not follow status and mask");
endmodule // wdr_watchdog

`default_nettype wire

// [test/watchdog_reset_timer_test.sv]
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_timer_test;
    import wdr_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        tick_2hz;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sys_reset_req;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          n_mismatch;
    int          num_checks;
    int          rst_cnt;
    int          base;

    wdr_watchdog u_wdr_watchdog (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .pstrb         (pstrb),
        .tick_2hz      (tick_2hz),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .sys_reset_req (sys_reset_req),
        .irq           (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, stimulus defaults and reset-request cycle counter
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        tick_2hz = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        rst_cnt = 0;
    end
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        if (sys_reset_req === 1'b1) begin
            rst_cnt <= rst_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Request held until the edge that sees pready high; answer taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Tick held long enough to cross the input synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            tick_2hz <= 1'b1;
            repeat (6) @(posedge pclk);
            tick_2hz <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        do_reset();
        apb(1'b0, 12'h038, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h044, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        $display("t_reset done");
    endtask

    task automatic t_disabled();
        base = rst_cnt;
        apb(1'b1, 12'h038, 32'h04);
        tick(6);
        chk(rst_cnt - base, 32'h0);
        $display("t_disabled done");
    endtask

    task automatic t_short();
        base = rst_cnt;
        apb(1'b1, 12'h038, 32'h08);
        tick(3);
        apb(1'b1, 12'h038, 32'h08);
        tick(3);
        chk(rst_cnt - base, 32'h0);
        tick(1);
        repeat (12) @(posedge pclk);
        chk(rst_cnt - base, 32'h8);
        apb(1'b0, 12'h038, 32'h0);
        chk(rdat, 32'h08);
        tick(6);
        chk(rst_cnt - base, 32'h8);
        $display("t_short done");
    endtask

    task automatic t_long();
        do_reset();
        base = rst_cnt;
        apb(1'b1, 12'h038, 32'h0c);
        tick(15);
        chk(rst_cnt - base, 32'h0);
        tick(1);
        repeat (12) @(posedge pclk);
        chk(rst_cnt - base, 32'h8);
        apb(1'b0, 12'h038, 32'h0);
        chk(rdat, 32'h0c);
        $display("t_long done");
    endtask

    task automatic t_irq();
        do_reset();
        apb(1'b0, 12'h038, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, 12'h044, 32'h3);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, 12'h038, 32'h08);
        tick(1);
        apb(1'b0, 12'h040, 32'h0);
        chk(rdat, 32'h3);
        chk(irq, 1'b1);
        apb(1'b1, 12'h044, 32'h1);
        apb(1'b1, 12'h040, 32'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 12'h040, 32'h0);
        chk(rdat, 32'h2);
        $display("t_irq done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog on the whole run
    initial begin
        t_reset();
        t_disabled();
        t_short();
        t_long();
        t_irq();
        end_of_test();
    end

    initial begin
        #(100 * 20000);
        n_mismatch++;
        end_of_test();
    end

endmodule // watchdog_reset_timer_test

`default_nettype wire
